// ===== design/rmd_decoder.sv
`timescale 1ns/100ps
`default_nettype none
`include "rmd_consts.svh"

module rmd_decoder #(
  parameter int ADDR_W = 42,
  parameter int NUM_ELEMENTS = 8,
  parameter int NUM_CORES = 1,
  parameter int NUM_THREADS = 2,
  parameter longint unsigned LOCAL_STORE_SIZE = 64'h40000,
  parameter longint unsigned TCB_STRIDE = 64'h20
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // relocation base load, software path
  input wire logic base_wr,
  input wire logic [ADDR_W-1:0] base_wr_data,
  // relocation base load, scan path
  input wire logic scan_en,
  input wire logic scan_in,
  input wire logic scan_done,
  output logic scan_out,
  // relocation base status
  output logic [ADDR_W-1:0] relocation_base,
  output logic base_valid,
  // access request
  input wire logic req_valid,
  input wire logic [ADDR_W-1:0] req_addr,
  // decode answer
  output logic resp_valid,
  output logic hit,
  output rmd_pkg::rmd_region_t region,
  output logic [15:0] unit_index,
  output logic [7:0] thread_index,
  output logic [31:0] local_offset
);

  // ----------------------------------------------------------------
  // derived layout
  // ----------------------------------------------------------------
  localparam int ELEM_POW = 1 << $clog2(NUM_ELEMENTS);
  localparam int CORE_POW = 1 << $clog2(NUM_CORES);
  localparam int WIN_PER_CORE = (NUM_THREADS + `RMD_THR_PER_WIN - 1) / `RMD_THR_PER_WIN;
  localparam int WIN_POW = 1 << $clog2(WIN_PER_CORE);
  localparam longint unsigned AREA = 64'h1 << $clog2(2 * LOCAL_STORE_SIZE);
  localparam longint unsigned HALF = AREA >> 1;
  localparam longint unsigned P1_BASE = 64'(ELEM_POW) * AREA;
  localparam longint unsigned HOST_BASE = P1_BASE + 64'(ELEM_POW) * `RMD_P1_STRIDE;
  localparam longint unsigned IIC_BASE = HOST_BASE + 64'(CORE_POW) * `RMD_HOST_STRIDE;
  localparam longint unsigned IIC_END = IIC_BASE
    + 64'(CORE_POW) * 64'(WIN_POW) * `RMD_IIC_STRIDE;
  localparam longint unsigned MAP_END = ((IIC_END + `RMD_PAD_ALIGN - 64'h1)
    / `RMD_PAD_ALIGN) * `RMD_PAD_ALIGN;
  localparam int MAP_W = $clog2(MAP_END);
  localparam int AREA_W = $clog2(AREA);
  localparam int STRIDE_W = $clog2(TCB_STRIDE);
  localparam int WIN_W = $clog2(WIN_POW);

  // ----------------------------------------------------------------
  // relocation base register
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] next_relocation_base;
  logic next_base_valid;

  // scan shifts toward the msb; scan_out is the bit falling off the top
  always_comb begin
    next_relocation_base = relocation_base;
    next_base_valid = base_valid;
    if (scan_en) begin
      next_relocation_base = {relocation_base[ADDR_W-2:0], scan_in};
      if (scan_done) begin
        next_base_valid = 1'b1;
      end
    end else if (base_wr) begin
      next_relocation_base = base_wr_data;
      next_base_valid = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      relocation_base <= ADDR_W'(`RMD_BASE_RESET);
      base_valid <= 1'b0;
    end else begin
      relocation_base <= next_relocation_base;
      base_valid <= next_base_valid;
    end
  end

  assign scan_out = relocation_base[ADDR_W-1];

  // ----------------------------------------------------------------
  // region decode
  // ----------------------------------------------------------------
  logic next_resp_valid;
  logic next_hit;
  rmd_pkg::rmd_region_t next_region;
  logic [15:0] next_unit_index;
  logic [7:0] next_thread_index;
  logic [31:0] next_local_offset;

  // low base bits are ignored: an unaligned base still decodes as aligned
  always_comb begin
    longint unsigned ofs;
    longint unsigned rel;
    longint unsigned idx;
    longint unsigned lo;
    longint unsigned win;
    longint unsigned sub;
    longint unsigned thr;
    ofs = 64'(req_addr[MAP_W-1:0]);
    rel = 64'h0;
    idx = 64'h0;
    lo = 64'h0;
    win = 64'h0;
    sub = 64'h0;
    thr = 64'h0;
    next_resp_valid = req_valid;
    next_hit = 1'b0;
    next_region = rmd_pkg::RMD_NONE;
    next_unit_index = 16'h0000;
    next_thread_index = 8'h00;
    next_local_offset = 32'h0000_0000;
    if (req_valid && base_valid
        && req_addr[ADDR_W-1:MAP_W] == relocation_base[ADDR_W-1:MAP_W]) begin
      if (ofs < P1_BASE) begin
        idx = ofs >> AREA_W;
        lo = ofs & (AREA - 64'h1);
        if (idx < 64'(NUM_ELEMENTS)) begin
          if (lo < LOCAL_STORE_SIZE) begin
            next_region = rmd_pkg::RMD_LOCAL_STORE;
            rel = lo;
          end else if (lo >= HALF && lo < HALF + `RMD_PS_SIZE) begin
            next_region = rmd_pkg::RMD_PROBLEM_STATE;
            rel = lo - HALF;
          end else if (lo >= HALF + `RMD_P2_OFS
                       && lo < HALF + `RMD_P2_OFS + `RMD_P2_SIZE) begin
            next_region = rmd_pkg::RMD_PRIVILEGE2;
            rel = lo - HALF - `RMD_P2_OFS;
          end
        end
      end else if (ofs < HOST_BASE) begin
        idx = (ofs - P1_BASE) / `RMD_P1_STRIDE;
        if (idx < 64'(NUM_ELEMENTS)) begin
          next_region = rmd_pkg::RMD_PRIVILEGE1;
          rel = (ofs - P1_BASE) % `RMD_P1_STRIDE;
        end
      end else if (ofs < IIC_BASE) begin
        idx = (ofs - HOST_BASE) / `RMD_HOST_STRIDE;
        if (idx < 64'(NUM_CORES)) begin
          next_region = rmd_pkg::RMD_HOST_CORE;
          rel = (ofs - HOST_BASE) % `RMD_HOST_STRIDE;
        end
      end else if (ofs < IIC_END) begin
        win = (ofs - IIC_BASE) / `RMD_IIC_STRIDE;
        idx = win >> WIN_W;
        sub = win & 64'(WIN_POW - 1);
        lo = (ofs - IIC_BASE) % `RMD_IIC_STRIDE;
        if (idx < 64'(NUM_CORES) && sub < 64'(WIN_PER_CORE)) begin
          if (lo < `RMD_IIC_IMPL_SIZE) begin
            next_region = rmd_pkg::RMD_INTR_IMPL;
            rel = lo;
            thr = sub * 64'(`RMD_THR_PER_WIN);
          end else begin
            thr = (lo - `RMD_TCB_OFS) >> STRIDE_W;
            if (thr < 64'(`RMD_THR_PER_WIN)
                && sub * 64'(`RMD_THR_PER_WIN) + thr < 64'(NUM_THREADS)) begin
              next_region = rmd_pkg::RMD_THREAD_BLOCK;
              rel = (lo - `RMD_TCB_OFS) & (TCB_STRIDE - 64'h1);
              thr = sub * 64'(`RMD_THR_PER_WIN) + thr;
            end
          end
        end
      end
      // pad and unused spans fall through as a hole
      if (next_region != rmd_pkg::RMD_NONE) begin
        next_hit = 1'b1;
        next_unit_index = idx[15:0];
        next_thread_index = thr[7:0];
        next_local_offset = rel[31:0];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      resp_valid <= 1'b0;
      hit <= 1'b0;
      region <= rmd_pkg::RMD_NONE;
      unit_index <= 16'h0000;
      thread_index <= 8'h00;
      local_offset <= 32'h0000_0000;
    end else begin
      resp_valid <= next_resp_valid;
      hit <= next_hit;
      region <= next_region;
      unit_index <= next_unit_index;
      thread_index <= next_thread_index;
      local_offset <= next_local_offset;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_base_load;
    @(posedge clock) disable iff (rst)
    (base_wr && !scan_en) |=> (relocation_base == $past(base_wr_data)) && base_valid;
  endproperty
  a_base_load: assert property (p_base_load) else $error("base write not taken");

  property p_no_base_no_hit;
    @(posedge clock) disable iff (rst)
    (req_valid && !base_valid) |=> resp_valid && !hit;
  endproperty
  a_no_base_no_hit: assert property (p_no_base_no_hit) else $error("hit before base");

  property p_base_is_ls0;
    @(posedge clock) disable iff (rst)
    (req_valid && base_valid && req_addr[MAP_W-1:0] == '0
      && req_addr[ADDR_W-1:MAP_W] == relocation_base[ADDR_W-1:MAP_W])
    |=> hit && region == rmd_pkg::RMD_LOCAL_STORE && unit_index == 16'h0000
      && local_offset == 32'h0000_0000;
  endproperty
  a_base_is_ls0: assert property (p_base_is_ls0) else $error("base is not element zero");

  property p_ls_bound;
    @(posedge clock) disable iff (rst)
    (hit && region == rmd_pkg::RMD_LOCAL_STORE)
    |-> 64'(local_offset) < LOCAL_STORE_SIZE && 64'(unit_index) < 64'(NUM_ELEMENTS);
  endproperty
  a_ls_bound: assert property (p_ls_bound) else $error("local store out of range");

  property p_ps_p2_bound;
    @(posedge clock) disable iff (rst)
    (hit && (region == rmd_pkg::RMD_PROBLEM_STATE || region == rmd_pkg::RMD_PRIVILEGE2))
    |-> local_offset <= 32'h0001_FFFF && 64'(unit_index) < 64'(NUM_ELEMENTS);
  endproperty
  a_ps_p2_bound: assert property (p_ps_p2_bound) else $error("element window overrun");

  property p_p1_bound;
    @(posedge clock) disable iff (rst)
    (hit && region == rmd_pkg::RMD_PRIVILEGE1)
    |-> local_offset <= 32'h0000_1FFF && 64'(unit_index) < 64'(NUM_ELEMENTS);
  endproperty
  a_p1_bound: assert property (p_p1_bound) else $error("privilege-1 overrun");

  property p_host_bound;
    @(posedge clock) disable iff (rst)
    (hit && region == rmd_pkg::RMD_HOST_CORE)
    |-> local_offset <= 32'h0000_0FFF && 64'(unit_index) < 64'(NUM_CORES);
  endproperty
  a_host_bound: assert property (p_host_bound) else $error("host window overrun");

  property p_iic_bound;
    @(posedge clock) disable iff (rst)
    (hit && region == rmd_pkg::RMD_INTR_IMPL) |-> local_offset <= 32'h0000_03FF;
  endproperty
  a_iic_bound: assert property (p_iic_bound) else $error("interrupt window overrun");

  property p_tcb_bound;
    @(posedge clock) disable iff (rst)
    (hit && region == rmd_pkg::RMD_THREAD_BLOCK)
    |-> 64'(thread_index) < 64'(NUM_THREADS) && 64'(local_offset) < TCB_STRIDE;
  endproperty
  a_tcb_bound: assert property (p_tcb_bound) else $error("thread block out of range");

  property p_one_answer;
    @(posedge clock) disable iff (rst)
    req_valid |=> resp_valid && (hit == (region != rmd_pkg::RMD_NONE));
  endproperty
  a_one_answer: assert property (p_one_answer) else $error("answer missing or mixed");

  property p_quiet;
    @(posedge clock) disable iff (rst)
    !req_valid |=> !resp_valid && !hit;
  endproperty
  a_quiet: assert property (p_quiet) else $error("answer without request");

endmodule : rmd_decoder

`default_nettype wire

// ===== design/rmd_consts.svh
// Overview of operation
// - at least one relocation base register
// - base loaded by software or scan first
// - element area twice local store; element zero at base
// - problem state at half area, x'20000 long
// - privilege-2 window x'20000 above problem state
// - privilege-1 windows after elements, x'2000 stride
// - host core windows after privilege-1, x'1000 stride
// - interrupt windows x'1000 each, x'400 implementation area
// - thread block at window plus x'400 plus stride
// - over sixteen threads adds more interrupt windows
// - element range rounded up, extras reserved
// - core range rounded up, extras reserved
// - map padded to 64 KB boundary
// - holes in the map give no hit
`ifndef RMD_CONSTS_SVH
`define RMD_CONSTS_SVH

`define RMD_PS_SIZE 64'h20000
`define RMD_P2_OFS 64'h20000
`define RMD_P2_SIZE 64'h20000
`define RMD_P1_STRIDE 64'h2000
`define RMD_HOST_STRIDE 64'h1000
`define RMD_IIC_STRIDE 64'h1000
`define RMD_IIC_IMPL_SIZE 64'h400
`define RMD_TCB_OFS 64'h400
`define RMD_THR_PER_WIN 16
`define RMD_PAD_ALIGN 64'h10000
`define RMD_BASE_RESET 64'h0

`endif

// ===== design/rmd_pkg.sv
`default_nettype none

package rmd_pkg;

  // region reported for a decoded access
  typedef enum logic [2:0] {
    RMD_NONE = 3'h0,
    RMD_LOCAL_STORE = 3'h1,
    RMD_PROBLEM_STATE = 3'h2,
    RMD_PRIVILEGE2 = 3'h3,
    RMD_PRIVILEGE1 = 3'h4,
    RMD_HOST_CORE = 3'h5,
    RMD_INTR_IMPL = 3'h6,
    RMD_THREAD_BLOCK = 3'h7
  } rmd_region_t;

endpackage : rmd_pkg

`default_nettype wire

// ===== tb/rmd_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// --------
// cores issuing real-address accesses
// --------
module rmd_host_model #(
  parameter int ADDR_W = 42
) (
  // clock
  input wire logic clock,
  // access request
  output logic req_valid,
  output logic [ADDR_W-1:0] req_addr,
  // software base load
  output logic base_wr,
  output logic [ADDR_W-1:0] base_wr_data
);
  initial begin
    req_valid = 1'b0;
    req_addr = '0;
    base_wr = 1'b0;
    base_wr_data = '0;
  end
  // idle lines scramble so a stale address never decodes by luck
  task automatic access(input logic v, input logic [ADDR_W-1:0] a);
    @(negedge clock);
    req_valid = v;
    req_addr = v ? a : ~req_addr;
  endtask : access
  // base loaded before traffic, aligned to the map size
  task automatic load_base(input logic [ADDR_W-1:0] b);
    @(negedge clock);
    req_valid = 1'b0;
    base_wr = 1'b1;
    base_wr_data = b;
    @(negedge clock);
    base_wr = 1'b0;
    base_wr_data = ~b;
  endtask : load_base
endmodule : rmd_host_model
`default_nettype wire

// ===== tb/real_address_map_decoder_tb.sv
`timescale 1ns/100ps
`default_nettype none
// --------
// decoder bench
// --------
module real_address_map_decoder_tb;
  logic clock, rst, scan_en, scan_in, scan_done, scan_out, base_wr, req_valid;
  logic base_valid, resp_valid, hit, pend_v, exp_bv;
  logic [41:0] base_wr_data, req_addr, relocation_base, exp_base, b2;
  rmd_pkg::rmd_region_t region;
  logic [15:0] unit_index;
  logic [7:0] thread_index;
  logic [31:0] local_offset;
  logic [59:0] pend_e;
  int fail_count = 0, comparisons = 0, cycles = 0;
  logic [22:0] corner [25] = '{23'h0, 23'h3FFFF, 23'h40000, 23'h5FFFF, 23'h60000,
    23'h7FFFF, 23'h380000, 23'h3FFFFF, 23'h400000, 23'h401FFF, 23'h40E000, 23'h40FFFF,
    23'h410000, 23'h410FFF, 23'h411000, 23'h4113FF, 23'h411400, 23'h41141F, 23'h411420,
    23'h41143F, 23'h411440, 23'h411FFF, 23'h412000, 23'h41FFFF, 23'h7FFFFF};
  // address width, local store size and thread stride stay at the module defaults
  rmd_host_model rmd_host_model_i (.clock(clock), .req_valid(req_valid),
    .req_addr(req_addr), .base_wr(base_wr), .base_wr_data(base_wr_data));
  rmd_decoder #(.ADDR_W(42), .NUM_ELEMENTS(8), .NUM_CORES(1), .NUM_THREADS(2))
    rmd_decoder_i (.clock(clock),
    .rst(rst), .base_wr(base_wr), .base_wr_data(base_wr_data), .scan_en(scan_en),
    .scan_in(scan_in), .scan_done(scan_done), .scan_out(scan_out),
    .relocation_base(relocation_base), .base_valid(base_valid), .req_valid(req_valid),
    .req_addr(req_addr), .resp_valid(resp_valid), .hit(hit), .region(region),
    .unit_index(unit_index), .thread_index(thread_index), .local_offset(local_offset));
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // fixed to the default layout: 8 elements, one core, two threads
  function automatic logic [59:0] exp_ans(input logic [41:0] a);
    logic [22:0] o = a[22:0];
    logic [18:0] w = a[18:0];
    logic [2:0] r = 3'h0;
    logic [15:0] u = 16'h0;
    logic [7:0] t = 8'h0;
    logic [31:0] f = 32'h0;
    if (exp_bv && a[41:23] == exp_base[41:23]) begin
      if (!o[22]) begin
        r = (w < 19'h40000) ? 3'h1 : ((w < 19'h60000) ? 3'h2 : 3'h3);
        u = 16'(o[21:19]);
        f = (r == 3'h1) ? 32'(w) : 32'(w[16:0]);
      end else if (o[22:16] == 7'h40) begin
        r = 3'h4;
        u = 16'(o[15:13]);
        f = 32'(o[12:0]);
      end else if (o[22:12] == 11'h410) begin
        r = 3'h5;
        f = 32'(o[11:0]);
      end else if (o[22:10] == 13'h1044) begin
        r = 3'h6;
        f = 32'(o[9:0]);
      end else if (o[22:6] == 17'h10450) begin
        r = 3'h7;
        t = 8'(o[5]);
        f = 32'(o[4:0]);
      end
    end
    return {r != 3'h0, r, u, t, f};
  endfunction : exp_ans
  // answer of the previous cycle is checked as the next request goes out
  task automatic step(input logic v, input logic [41:0] a);
    rmd_host_model_i.access(v, a);
    check("resp_valid", 64'(resp_valid), 64'(pend_v));
    if (pend_v)
      check("answer", 64'({hit, region, unit_index, thread_index, local_offset}),
        64'(pend_e));
    pend_v = v;
    pend_e = exp_ans(a);
  endtask : step
  task automatic scan_load(input logic [41:0] b);
    for (int i = 41; i >= 0; i--) begin
      @(negedge clock);
      scan_in = b[i];
      scan_done = (i == 0);
    end
    @(negedge clock);
    scan_en = 1'b0;
    scan_done = 1'b0;
    check("scan", 64'({relocation_base, base_valid, scan_out}), 64'({b, 1'b1, b[41]}));
    exp_base = b;
    exp_bv = 1'b1;
  endtask : scan_load
  task automatic rand_run(input int n);
    logic [41:0] a;
    for (int i = 0; i < n; i++) begin
      a = exp_base | 42'($urandom % 32'h440000);
      if ($urandom % 16 == 0)
        a = {19'($urandom), a[22:0]};
      step(1'($urandom % 4 != 0), a);
    end
    step(1'b0, '0);
  endtask : rand_run
  initial begin
    void'($urandom(32'h6A94));
    {rst, scan_en, scan_in, scan_done, pend_v, exp_bv} = 6'h20;
    exp_base = '0;
    repeat (16) @(negedge clock);
    rst = 1'b0;
    check("reset", 64'({relocation_base, base_valid, scan_out}), 64'h0);
    step(1'b1, 42'h10);
    step(1'b0, '0);
    // shift path wins over a software write in the same cycle
    scan_en = 1'b1;
    rmd_host_model_i.load_base({19'h7FFFF, 23'h0});
    check("base_valid", 64'(base_valid), 64'h0);
    scan_load({19'h5A5A5, 23'h0});
    foreach (corner[i])
      step(1'b1, exp_base | 42'(corner[i]));
    step(1'b1, exp_base ^ 42'h800010);
    rand_run(300);
    b2 = {19'($urandom), 23'h0};
    rmd_host_model_i.load_base(b2);
    check("base_wr", 64'({relocation_base, base_valid}), 64'({b2, 1'b1}));
    exp_base = b2;
    rand_run(300);
    rst = 1'b1;
    @(negedge clock);
    rst = 1'b0;
    exp_bv = 1'b0;
    check("reset", 64'({relocation_base, base_valid}), 64'h0);
    step(1'b1, b2 | 42'h10);
    step(1'b0, '0);
    stop_test();
  end
endmodule : real_address_map_decoder_tb
`default_nettype wire
